// *** logic/nvram_ctrl.v ***
// Host controller driving the shadowed SRAM through its pins
// Functional notes
// - Six key reads in order start store (0FC0) or recall (0C63).
// - Host keeps write strobe high during all six key accesses.
// - Host never issues the reserved sequence ending 339C.
// - Hardware store request holds the line low at least 20 ns.
// - Store/busy line is open drain, shared, pulls nothing else up.
// - One select pulse per key address.
`timescale 1ns/1ps
`include "nvram_ctrl_map.vh"
module nvram_ctrl #(
    parameter PWRUP_CYC  = `PWRUP_CYC,
    parameter STORE_CYC  = `STORE_CYC,
    parameter RECALL_CYC = `RECALL_CYC
) (
    input  wire        i_clk,
    input  wire        i_arst_n,
    input  wire        i_req,
    input  wire [1:0]  i_cmd,
    input  wire [14:0] i_addr,
    input  wire [7:0]  i_wdata,
    output wire        o_ready,
    output reg         o_done,
    output reg  [7:0]  o_rdata,
    output reg         o_busy,
    output reg         o_ce_n,
    output reg         o_we_n,
    output reg         o_oe_n,
    output reg  [14:0] o_addr,
    output reg  [7:0]  o_data_out,
    output reg         o_data_oe,
    input  wire [7:0]  i_data_in,
    output wire        o_store_busy_line_out,
    output reg         o_store_busy_line_oe,
    input  wire        i_store_busy_line_in
);
    localparam CMD_READ = 2'd0, CMD_WRITE = 2'd1, CMD_STORE = 2'd2, CMD_RECALL = 2'd3;
    localparam ST_PWRUP = 3'd0, ST_IDLE = 3'd1, ST_ACC = 3'd2, ST_GAP = 3'd3,
               ST_NVWAIT = 3'd4, ST_HSBLOW = 3'd5, ST_HSBREL = 3'd6;
    localparam integer      ACC_I  = `ACC_CYC;
    localparam integer      PULS_I = `HSB_PULSE_CYC;
    localparam integer      REL_I  = `HSB_REL_CYC;
    localparam [`CNT_W-1:0] ACC_C  = ACC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] PULS_C = PULS_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] REL_C  = REL_I[`CNT_W-1:0];

    reg  [2:0]        state_q;
    reg  [`CNT_W-1:0] cnt_q;
    reg  [2:0]        key_idx_q;
    reg               is_hw_q;
    reg               last_wr_q;
    reg               hsb_s1_q;
    reg               hsb_s2_q;

    // Key address table, step 5 chooses store or recall
    function [14:0] key_addr;
        input [2:0] idx;
        input       rec;
        begin
            case (idx)
                3'd0:    key_addr = `KEY_ADDR_0;
                3'd1:    key_addr = `KEY_ADDR_1;
                3'd2:    key_addr = `KEY_ADDR_2;
                3'd3:    key_addr = `KEY_ADDR_3;
                3'd4:    key_addr = `KEY_ADDR_4;
                default: key_addr = rec ? `KEY_ADDR_RECALL : `KEY_ADDR_STORE;
            endcase
        end
    endfunction

    assign o_store_busy_line_out = 1'b0;
    assign o_ready = (state_q == ST_IDLE) && hsb_s2_q;

    // Two-stage synchroniser on the shared busy line
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hsb_s1_q <= 1'b1;
            hsb_s2_q <= 1'b1;
        end else begin
            hsb_s1_q <= i_store_busy_line_in;
            hsb_s2_q <= hsb_s1_q;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q              <= ST_PWRUP;
            cnt_q                <= {`CNT_W{1'b0}};
            key_idx_q            <= 3'd0;
            is_hw_q              <= 1'b0;
            last_wr_q            <= 1'b0;
            o_done               <= 1'b0;
            o_rdata              <= 8'h00;
            o_busy               <= 1'b1;
            o_ce_n               <= 1'b1;
            o_we_n               <= 1'b1;
            o_oe_n               <= 1'b1;
            o_addr               <= 15'h0000;
            o_data_out           <= 8'h00;
            o_data_oe            <= 1'b0;
            o_store_busy_line_oe <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_q)
                ST_PWRUP: begin
                    // Part recalls on its own at power-up; keep off the bus
                    if (cnt_q == PWRUP_CYC[`CNT_W-1:0] - 1'b1) begin
                        cnt_q   <= {`CNT_W{1'b0}};
                        state_q <= ST_IDLE;
                        o_busy  <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (i_req && hsb_s2_q) begin
                        o_busy <= 1'b1;
                        cnt_q  <= {`CNT_W{1'b0}};
                        case (i_cmd)
                            CMD_READ, CMD_WRITE: begin
                                last_wr_q <= (i_cmd == CMD_WRITE);
                                o_addr    <= i_addr;
                                // Strobe, gate and select set on the same edge; gate high in writes keeps the part's drivers off
                                o_we_n     <= (i_cmd != CMD_WRITE);
                                o_oe_n     <= (i_cmd == CMD_WRITE);
                                o_data_out <= i_wdata;
                                o_data_oe  <= (i_cmd == CMD_WRITE);
                                o_ce_n     <= 1'b0;
                                state_q    <= ST_ACC;
                            end
                            CMD_STORE: begin
                                // Pulled-low line: part stores only if it saw a write
                                is_hw_q              <= 1'b1;
                                o_store_busy_line_oe <= 1'b1;
                                state_q              <= ST_HSBLOW;
                            end
                            default: begin
                                // Software recall via the key sequence
                                is_hw_q   <= 1'b0;
                                // A stale write flag would turn the last key into a store
                                last_wr_q <= 1'b0;
                                key_idx_q <= 3'd0;
                                o_addr    <= key_addr(3'd0, 1'b1);
                                o_we_n    <= 1'b1;
                                o_oe_n    <= 1'b1;
                                o_ce_n    <= 1'b0;
                                state_q   <= ST_ACC;
                            end
                        endcase
                        if (i_cmd == CMD_READ || i_cmd == CMD_WRITE) begin
                            is_hw_q   <= 1'b0;
                            key_idx_q <= 3'd7;
                        end
                    end
                end
                ST_ACC: begin
                    if (cnt_q == ACC_C) begin
                        o_ce_n    <= 1'b1;
                        o_we_n    <= 1'b1;
                        o_oe_n    <= 1'b1;
                        o_data_oe <= 1'b0;
                        cnt_q     <= {`CNT_W{1'b0}};
                        if (key_idx_q == 3'd7) begin
                            if (!last_wr_q)
                                o_rdata <= i_data_in;
                            o_done  <= 1'b1;
                            o_busy  <= 1'b0;
                            state_q <= ST_IDLE;
                        end else if (key_idx_q == 3'd5) begin
                            state_q <= ST_NVWAIT;
                        end else begin
                            state_q <= ST_GAP;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_GAP: begin
                    // Back-to-back key reads, nothing else between them
                    key_idx_q <= key_idx_q + 1'b1;
                    o_addr    <= key_addr(key_idx_q + 1'b1, ~last_wr_q & ~is_hw_q & 1'b1);
                    o_ce_n    <= 1'b0;
                    state_q   <= ST_ACC;
                end
                ST_NVWAIT: begin
                    // Part ignores all pins until its transfer is over
                    if (cnt_q == (last_wr_q ? STORE_CYC[`CNT_W-1:0]
                                            : RECALL_CYC[`CNT_W-1:0])) begin
                        o_done  <= 1'b1;
                        o_busy  <= 1'b0;
                        cnt_q   <= {`CNT_W{1'b0}};
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_HSBLOW: begin
                    if (cnt_q == PULS_C) begin
                        o_store_busy_line_oe <= 1'b0;
                        cnt_q                <= {`CNT_W{1'b0}};
                        state_q              <= ST_HSBREL;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_HSBREL: begin
                    // Part holds the line low while storing; then allow the rise to settle
                    if (!hsb_s2_q) begin
                        cnt_q <= {`CNT_W{1'b0}};
                    end else if (cnt_q == REL_C) begin
                        o_done  <= 1'b1;
                        o_busy  <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** logic/nvram_ctrl_map.vh ***
// Constants for the host controller of the shadowed 32K x 8 SRAM
`ifndef NVRAM_CTRL_MAP_VH
`define NVRAM_CTRL_MAP_VH
`define KEY_ADDR_0        15'h0E38
`define KEY_ADDR_1        15'h31C7
`define KEY_ADDR_2        15'h03E0
`define KEY_ADDR_3        15'h3C1F
`define KEY_ADDR_4        15'h303F
`define KEY_ADDR_STORE    15'h0FC0
`define KEY_ADDR_RECALL   15'h0C63
`define KEY_ADDR_TEST     15'h339C
`define CLK_PERIOD_NS     5
`define ACC_TIME_NS       45
`define ACC_CYC           ((`ACC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HSB_PULSE_NS      20
`define HSB_PULSE_CYC     ((`HSB_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HSB_REL_NS        700
`define HSB_REL_CYC       ((`HSB_REL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRUP_US          650
`define PWRUP_CYC         (`PWRUP_US * 1000 / `CLK_PERIOD_NS)
`define STORE_MS          10
`define STORE_CYC         (`STORE_MS * 1000000 / `CLK_PERIOD_NS)
`define RECALL_US         20
`define RECALL_CYC        (`RECALL_US * 1000 / `CLK_PERIOD_NS)
`define CNT_W             24
`endif

// *** test/nvram_ctrl_assertions.sv ***
// Pin-side checks on the nvSRAM host controller
`timescale 1ns/1ps
`include "nvram_ctrl_map.vh"
module nvram_ctrl_assertions (
    input wire        i_clk,
    input wire        i_arst_n,
    input wire        i_req,
    input wire [1:0]  i_cmd,
    input wire        o_ready,
    input wire        o_done,
    input wire        o_ce_n,
    input wire        o_we_n,
    input wire        o_oe_n,
    input wire [14:0] o_addr,
    input wire        o_store_busy_line_out,
    input wire        o_store_busy_line_oe,
    input wire        i_store_busy_line_in
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_done_pulse; o_done |=> !o_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_pwrup; $rose(i_arst_n) |-> !o_ready [*8]; endproperty
    a_pwrup: assert property (p_pwrup) else $error("ready during power-up");
    property p_ready_line; o_ready |-> $past(i_store_busy_line_in, 2); endproperty
    a_ready_line: assert property (p_ready_line) else $error("ready with line low");
    property p_write_gate; !o_we_n |-> o_oe_n; endproperty
    a_write_gate: assert property (p_write_gate) else $error("gate low in write");
    property p_access; $fell(o_ce_n) |-> !o_ce_n [*8]; endproperty
    a_access: assert property (p_access) else $error("select pulse short");
    property p_read_time; i_req && o_ready && i_cmd == 2'h0 |-> ##[10:11] o_done; endproperty
    a_read_time: assert property (p_read_time) else $error("read not done");
    property p_key_we; !o_ce_n && o_addr == `KEY_ADDR_RECALL |-> o_we_n; endproperty
    a_key_we: assert property (p_key_we) else $error("strobe low in key");
    property p_hsb_pulse; $rose(o_store_busy_line_oe) |-> o_store_busy_line_oe [*4]; endproperty
    a_hsb_pulse: assert property (p_hsb_pulse) else $error("line pulse short");
    property p_hsb_od; o_store_busy_line_oe |-> !o_store_busy_line_out; endproperty
    a_hsb_od: assert property (p_hsb_od) else $error("line driven high");
    c_read: cover property (i_req && o_ready && i_cmd == 2'h0);
    c_recall: cover property ($fell(o_ce_n) && o_addr == `KEY_ADDR_RECALL);
    c_hsb: cover property ($rose(o_store_busy_line_oe));
endmodule
bind nvram_ctrl nvram_ctrl_assertions nvram_ctrl_assertions_i (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_req(i_req), .i_cmd(i_cmd), .o_ready(o_ready), .o_done(o_done),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr),
    .o_store_busy_line_out(o_store_busy_line_out), .o_store_busy_line_oe(o_store_busy_line_oe),
    .i_store_busy_line_in(i_store_busy_line_in));

// *** test/nvram_ctrl_tb_top.sv ***
// Self-checking bench for the nvSRAM host controller
`timescale 1ns/1ps
`include "nvram_ctrl_map.vh"
module nvram_ctrl_tb_top;
    typedef struct {logic [1:0] c; logic [14:0] a; logic [7:0] d;} row_t;
    logic        i_clk = 1'b0, i_arst_n = 1'b0, i_req = 1'b0, tb_pull = 1'b0;
    logic [1:0]  i_cmd = 2'h0;
    logic [14:0] i_addr = 15'h0000;
    logic [7:0]  i_wdata = 8'h00;
    wire         o_ready, o_done, o_busy, o_ce_n, o_we_n, o_oe_n, o_data_oe, lo, oe, pull;
    wire  [7:0]  o_rdata, o_data_out, dq, stores, recalls;
    wire  [14:0] o_addr;
    wire         store_busy_line = ~(oe | pull | tb_pull);
    int          error_cnt = 0, num_checks = 0;
    row_t        rows [6] = '{'{2'h1, 15'h0000, 8'hA5}, '{2'h1, 15'h7FFF, 8'h3C},
        '{2'h0, 15'h0000, 8'hA5}, '{2'h0, 15'h7FFF, 8'h3C},
        '{2'h1, `KEY_ADDR_0, 8'h11}, '{2'h0, `KEY_ADDR_0, 8'h11}};
    nvram_ctrl #(.PWRUP_CYC(20), .STORE_CYC(400), .RECALL_CYC(20)) nvram_ctrl_i (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .i_req(i_req), .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .o_busy(o_busy), .o_ce_n(o_ce_n),
        .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_data_out(o_data_out),
        .o_data_oe(o_data_oe), .i_data_in(dq), .o_store_busy_line_out(lo),
        .o_store_busy_line_oe(oe), .i_store_busy_line_in(store_busy_line));
    nvsram_model nvsram_model_i (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
        .i_addr(o_addr), .i_dq(o_data_out), .i_hsb(store_busy_line), .o_dq(dq), .o_pull(pull),
        .o_stores(stores), .o_recalls(recalls));
    initial forever #2.5 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_cmd(input logic [1:0] c, input logic [14:0] a, input logic [7:0] d);
        int n = 0;
        while (o_ready !== 1'b1 && n < 3000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk(o_ready, 32'h1);
        i_req = 1'b1;
        i_cmd = c;
        i_addr = a;
        i_wdata = d;
        @(posedge i_clk);
        #1 i_req = 1'b0;
        chk(o_busy, 32'h1);
        n = 0;
        while (o_done !== 1'b1 && n < 5000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk(o_done, 32'h1);
        chk(o_busy, 32'h0);
    endtask
    initial begin
        #50000 error_cnt++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        #1 chk({o_busy, o_ce_n, o_we_n, o_oe_n, oe, o_data_oe, lo}, 32'h78);
        repeat (8) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
        repeat (15) @(posedge i_clk);
        #1 chk(o_ready, 32'h0);
        foreach (rows[i]) begin
            do_cmd(rows[i].c, rows[i].a, rows[i].d);
            if (rows[i].c == 2'h0) chk(o_rdata, rows[i].d);
        end
        do_cmd(2'h2, 15'h0000, 8'h00);
        chk(stores, 32'h1);
        // No write since the last store, so the part must skip it
        do_cmd(2'h2, 15'h0000, 8'h00);
        chk(stores, 32'h1);
        do_cmd(2'h1, 15'h0000, 8'h00);
        do_cmd(2'h3, 15'h0000, 8'h00);
        chk(recalls, 32'h1);
        do_cmd(2'h0, 15'h0000, 8'h00);
        chk(o_rdata, 32'hA5);
        tb_pull = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 chk(o_ready, 32'h0);
        // Request stands through the refusal and is taken once the line is high again
        i_cmd = 2'h0;
        i_addr = 15'h7FFF;
        i_req = 1'b1;
        repeat (20) @(posedge i_clk);
        #1 chk(o_ce_n, 32'h1);
        tb_pull = 1'b0;
        do_cmd(2'h0, 15'h7FFF, 8'h00);
        chk(o_rdata, 32'h3C);
        summarize();
    end
endmodule

// *** test/nvsram_model.sv ***
// Behavioural model of the shadowed SRAM part
`timescale 1ns/1ps
`include "nvram_ctrl_map.vh"
module nvsram_model #(parameter int STORE_NS = 300, parameter int RECALL_NS = 80) (
    input  wire        i_ce_n,
    input  wire        i_we_n,
    input  wire        i_oe_n,
    input  wire [14:0] i_addr,
    input  wire [7:0]  i_dq,
    input  wire        i_hsb,
    output logic [7:0] o_dq,
    output logic       o_pull,
    output logic [7:0] o_stores,
    output logic [7:0] o_recalls
);
    logic [7:0]  sram [0:32767];
    logic [7:0]  nv [0:32767];
    logic [14:0] keys [0:4] = '{`KEY_ADDR_0, `KEY_ADDR_1, `KEY_ADDR_2, `KEY_ADDR_3, `KEY_ADDR_4};
    logic [14:0] a_q;
    logic [7:0]  d_q;
    logic [7:0]  last = 8'h00;
    logic        w_q;
    logic        dirty = 1'b0;
    logic        busy = 1'b1;
    int          key = 0;
    wire         drv = !i_ce_n && i_we_n && !i_oe_n && !busy && i_hsb;
    assign o_dq = drv ? sram[i_addr] : ~last;
    always @(o_dq) if (drv) last = o_dq;
    task automatic xfer(input bit st);
        busy = 1'b1;
        #(st ? STORE_NS : RECALL_NS);
        foreach (nv[i]) if (st) nv[i] = sram[i]; else sram[i] = nv[i];
        if (st) begin
            o_stores++;
            dirty = 1'b0;
        end else o_recalls++;
        busy = 1'b0;
    endtask
    initial begin
        o_pull = 1'b0;
        o_stores = 8'h00;
        o_recalls = 8'h00;
        foreach (nv[i]) nv[i] = 8'h00;
        foreach (sram[i]) sram[i] = 8'h00;
        #50 busy = 1'b0;
    end
    // Sample after the select edge so same-edge pin updates have landed
    always @(negedge i_ce_n) begin
        #1;
        a_q = i_addr;
        w_q = i_we_n;
        d_q = i_dq;
    end
    always @(posedge i_ce_n) if (!busy && i_hsb) begin
        if (!w_q) begin
            sram[a_q] = d_q;
            dirty = 1'b1;
            key = 0;
        end else if (key == 5 && a_q == `KEY_ADDR_STORE) begin
            key = 0;
            xfer(1'b1);
        end else if (key == 5 && a_q == `KEY_ADDR_RECALL) begin
            key = 0;
            xfer(1'b0);
        end else if (key < 5 && a_q == keys[key]) key++;
        else key = (a_q == keys[0]);
    end
    always @(negedge i_hsb) if (!busy && dirty) begin
        o_pull = 1'b1;
        xfer(1'b1);
        o_pull = 1'b0;
    end
endmodule
